// ### bench/acd_clip_detector_bench.sv
// Purpose: register and sample-stream tests for the overload detector
// Assumes: apb answers within 20 cycles
// Notes: window 4 and 3 samples keep the run short
`timescale 1ns/1ps
`define CHK(nm, x, g) begin cmp_count++; if ((g) !== (x)) begin bad_count++; \
   $display("CHECK FAILED %s exp %h got %h", nm, x, g); end end
module acd_clip_detector_bench
   import acd_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   acd_apb_req_s req = '0;
   logic [DATA_W-1:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic sample_valid_i = 1'b0;
   logic [SMP_W-1:0] sample_i = '0;
   logic [SMP_W-1:0] normal_err_i = '0;
   logic overload_o;
   logic [ACC_W-1:0] loop_accum_o;
   int bad_count = 0;
   int cmp_count = 0;
   logic exp_ov = 1'b0;
   logic [ACC_W-1:0] exp_acc = '0;
   logic [DATA_W-1:0] q;
   logic e;
   logic [15:0] cv [6] = '{16'h1000, 16'h0100, 16'h0004, 16'h0003, 16'h0202, 16'h0010};
   logic [15:0] sv [13] = '{16'hefff, 16'h1000, 16'hf000, 16'h0000, 16'h7fff, 16'h8000,
      16'h0020, 16'h2000, 16'h2000, 16'h0100, 16'h0050, 16'hffb0, 16'h2000};
   localparam logic [12:0] OVM = 13'h07e0;
   always #2 ref_clk_i = ~ref_clk_i;
   acd_clip_detector u_dut (.ref_clk_i, .rst_n_i, .apb_req_i(req), .prdata_o, .pready_o,
      .pslverr_o, .sample_valid_i, .sample_i, .normal_err_i, .overload_o, .loop_accum_o);
   function automatic logic [ADDR_W-1:0] ad(input logic [IDX_W-1:0] i);
      return {i, 2'b00};
   endfunction
   task automatic report_and_stop();
      if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ready, read data and error are all taken at the rising edge that sees ready
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      @(posedge ref_clk_i);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge ref_clk_i);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (pready_o !== 1'b1) begin
         bad_count++;
         report_and_stop();
      end
      q = prdata_o;
      e = pslverr_o;
      req <= '0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x, input logic xe);
      apb(1'b0, a, '0);
      `CHK("prdata", x, q)
      `CHK("pslverr", xe, e)
   endtask
   task automatic smp(input logic [SMP_W-1:0] s, input logic ov);
      @(posedge ref_clk_i);
      sample_valid_i <= 1'b1;
      sample_i <= s;
      normal_err_i <= ~s;
      @(posedge ref_clk_i);
      sample_valid_i <= 1'b0;
      exp_acc += exp_ov ? ACC_W'($signed(cv[5])) : ACC_W'($signed(~s));
      exp_ov = ov;
      @(negedge ref_clk_i);
      `CHK("overload", exp_ov, overload_o)
      `CHK("accum", exp_acc, loop_accum_o)
   endtask
   initial begin
      repeat (16) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 6; i++) rd(ad(IDX_W'(IDX_UPPER_THRESH + i)), '0, 1'b0);
      smp(16'h7fff, 1'b0);
      smp(16'h8000, 1'b0);
      rd(ad(10'h040), '0, 1'b1);
      for (int i = 0; i < 6; i++) apb(1'b1, ad(IDX_W'(IDX_UPPER_THRESH + i)), {16'hffff, cv[i]});
      apb(1'b1, ad(IDX_UPPER_THRESH) + 12'h001, '1);
      for (int i = 0; i < 6; i++) rd(ad(IDX_W'(IDX_UPPER_THRESH + i)), {16'h0, cv[i]}, 1'b0);
      for (int i = 0; i < 13; i++) begin
         smp(sv[i], OVM[i]);
         if (i == 2) rd(ad(IDX_STATUS), 32'h0000_0100, 1'b0);
      end
      rd(ad(IDX_ACCUM), exp_acc, 1'b0);
      report_and_stop();
   end
endmodule // acd_clip_detector_bench

// ### bench/acd_clip_sva.sv
// Purpose: port checks for the overload detector
// Assumes: one clock, asynchronous active-low reset
// Notes: thresholds are not visible here, so causes are checked loosely
`timescale 1ns/1ps
module acd_clip_sva
   import acd_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire acd_apb_req_s apb_req_i,
   input wire logic [DATA_W-1:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic sample_valid_i,
   input wire logic [SMP_W-1:0] sample_i,
   input wire logic [SMP_W-1:0] normal_err_i,
   input wire logic overload_o,
   input wire logic [ACC_W-1:0] loop_accum_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence access_s;
      apb_req_i.psel && apb_req_i.penable && !pready_o;
   endsequence
   sequence take_s;
      sample_valid_i && !overload_o;
   endsequence
   apb_answer_a: assert property (access_s |=> pready_o)
      else $error("no answer after access");
   apb_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   rdata_idle_a: assert property (!pready_o |-> prdata_o == '0)
      else $error("read data outside answer");
   bad_addr_a: assert property (apb_req_i.penable && apb_req_i.paddr[1:0] != 2'b00
      && pready_o |-> pslverr_o) else $error("misaligned access not refused");
   accum_normal_a: assert property (take_s |=> loop_accum_o ==
      $past(loop_accum_o) + ACC_W'($signed($past(normal_err_i))))
      else $error("normal error not accumulated");
   accum_hold_a: assert property (!sample_valid_i |=> $stable(loop_accum_o))
      else $error("accumulator moved without sample");
   raise_cause_a: assert property ($rose(overload_o) |->
      $past(sample_valid_i) && $past(sample_i) != 16'h0000) else $error("bad raise");
   clear_cause_a: assert property ($fell(overload_o) |-> $past(sample_valid_i))
      else $error("clear without sample");
   event_hold_a: assert property (!sample_valid_i |=> $stable(overload_o))
      else $error("overload moved without sample");
endmodule // acd_clip_sva

bind acd_clip_detector acd_clip_sva u_sva (.ref_clk_i, .rst_n_i, .apb_req_i, .prdata_o,
   .pready_o, .pslverr_o, .sample_valid_i, .sample_i, .normal_err_i, .overload_o,
   .loop_accum_o);

// ### verilog/acd_clip_detector.sv
// Purpose: overload detection for one receive gain loop, with error injection
// Assumes: samples and normal error come from logic on ref_clk_i, one per valid
// Notes: registers reached over APB with one wait state; unmapped -> pslverr
`timescale 1ns/1ps

module acd_clip_detector
   import acd_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire acd_apb_req_s apb_req_i,
   output logic [DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic sample_valid_i,
   input wire logic [SMP_W-1:0] sample_i,
   input wire logic [SMP_W-1:0] normal_err_i,
   output logic overload_o,
   output logic [ACC_W-1:0] loop_accum_o
);

   // ---------------- register file ----------------
   acd_cfg_s cfg_reg;
   acd_cfg_s cfg_next;
   logic [DATA_W-1:0] prdata_reg;
   logic [DATA_W-1:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;

   // detector and accumulator state
   acd_state_e state_reg;
   acd_state_e state_next;
   logic [SMP_W-1:0] uwin_cnt_reg;
   logic [SMP_W-1:0] uwin_cnt_next;
   logic [SMP_W-1:0] lwin_cnt_reg;
   logic [SMP_W-1:0] lwin_cnt_next;
   logic [CNT_W-1:0] uhit_cnt_reg;
   logic [CNT_W-1:0] uhit_cnt_next;
   logic [CNT_W-1:0] lhit_cnt_reg;
   logic [CNT_W-1:0] lhit_cnt_next;
   logic [ACC_W-1:0] acc_reg;
   logic [ACC_W-1:0] acc_next;

   logic access;
   logic [IDX_W-1:0] idx;
   logic aligned;

   assign access = apb_req_i.psel & apb_req_i.penable;
   assign idx = apb_req_i.paddr[ADDR_W-1:IDX_LSB];
   assign aligned = (apb_req_i.paddr[IDX_LSB-1:0] == 2'h0);

   always_comb begin
      logic hit;
      logic [DATA_W-1:0] rd;
      hit = 1'b1;
      rd = RST_DATA;
      cfg_next = cfg_reg;
      unique case (idx)
         IDX_UPPER_THRESH: rd = {16'h0000, cfg_reg.upper_thresh};
         IDX_LOWER_THRESH: rd = {16'h0000, cfg_reg.lower_thresh};
         IDX_UPPER_WINDOW: rd = {16'h0000, cfg_reg.upper_window};
         IDX_LOWER_WINDOW: rd = {16'h0000, cfg_reg.lower_window};
         IDX_SAMPLE_COUNTS: rd = {16'h0000, cfg_reg.upper_target, cfg_reg.lower_target};
         IDX_ERROR_INJECT: rd = {16'h0000, cfg_reg.error_inject};
         IDX_STATUS: begin
            rd[FLD_ST_ACTIVE] = (state_reg == ST_CLIP);
            rd[FLD_ST_UHITS_LSB +: CNT_W] = uhit_cnt_reg;
            rd[FLD_ST_LHITS_LSB +: CNT_W] = lhit_cnt_reg;
         end
         IDX_ACCUM: rd = acc_reg;
         default: hit = 1'b0;
      endcase
      hit = hit & aligned;
      // second access cycle completes; one wait state keeps all outputs registered
      pready_next = access & ~pready_reg;
      pslverr_next = access & ~pready_reg & ~hit;
      prdata_next = (access & ~pready_reg & ~apb_req_i.pwrite & hit) ? rd : RST_DATA;
      if (access && pready_reg && apb_req_i.pwrite && hit) begin
         unique case (idx)
            IDX_UPPER_THRESH: cfg_next.upper_thresh = apb_req_i.pwdata[SMP_W-1:0];
            IDX_LOWER_THRESH: cfg_next.lower_thresh = apb_req_i.pwdata[SMP_W-1:0];
            IDX_UPPER_WINDOW: cfg_next.upper_window = apb_req_i.pwdata[SMP_W-1:0];
            IDX_LOWER_WINDOW: cfg_next.lower_window = apb_req_i.pwdata[SMP_W-1:0];
            IDX_SAMPLE_COUNTS: begin
               cfg_next.upper_target = apb_req_i.pwdata[FLD_UPPER_TGT_LSB +: CNT_W];
               cfg_next.lower_target = apb_req_i.pwdata[FLD_LOWER_TGT_LSB +: CNT_W];
            end
            IDX_ERROR_INJECT: cfg_next.error_inject = apb_req_i.pwdata[SMP_W-1:0];
            default: cfg_next = cfg_reg;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_reg <= '{upper_thresh: RST_CFG16, lower_thresh: RST_CFG16,
                      upper_window: RST_CFG16, lower_window: RST_CFG16,
                      upper_target: RST_CNT8, lower_target: RST_CNT8,
                      error_inject: RST_CFG16};
         prdata_reg <= RST_DATA;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // ---------------- overload detector ----------------
   // magnitude of a two's complement sample; the most negative code saturates
   logic [SMP_W-1:0] mag;
   logic above_upper;
   logic below_lower;

   always_comb begin
      if (sample_i[SMP_W-1]) begin
         mag = (sample_i == 16'h8000) ? 16'h7fff : SMP_W'(~sample_i + 16'h0001);
      end else begin
         mag = sample_i;
      end
   end

   assign above_upper = (mag > cfg_reg.upper_thresh);
   assign below_lower = (mag < cfg_reg.lower_thresh);

   always_comb begin
      logic [CNT_W-1:0] uhits;
      logic [CNT_W-1:0] lhits;
      logic [SMP_W-1:0] uwin;
      logic [SMP_W-1:0] lwin;
      uhits = uhit_cnt_reg + CNT_W'(above_upper);
      lhits = lhit_cnt_reg + CNT_W'(below_lower);
      uwin = uwin_cnt_reg + 16'h0001;
      lwin = lwin_cnt_reg + 16'h0001;
      state_next = state_reg;
      uwin_cnt_next = uwin_cnt_reg;
      lwin_cnt_next = lwin_cnt_reg;
      uhit_cnt_next = uhit_cnt_reg;
      lhit_cnt_next = lhit_cnt_reg;
      if (sample_valid_i) begin
         unique case (state_reg)
            ST_WATCH: begin
               // zero target or zero window leaves detection idle
               if (cfg_reg.upper_target != RST_CNT8 && uhits == cfg_reg.upper_target
                   && cfg_reg.upper_window != RST_CFG16) begin
                  state_next = ST_CLIP;
                  uwin_cnt_next = RST_CFG16;
                  uhit_cnt_next = RST_CNT8;
               end else if (uwin >= cfg_reg.upper_window) begin
                  uwin_cnt_next = RST_CFG16;
                  uhit_cnt_next = RST_CNT8;
               end else begin
                  uwin_cnt_next = uwin;
                  uhit_cnt_next = uhits;
               end
               lwin_cnt_next = RST_CFG16;
               lhit_cnt_next = RST_CNT8;
            end
            ST_CLIP: begin
               if (cfg_reg.lower_target != RST_CNT8 && lhits == cfg_reg.lower_target
                   && cfg_reg.lower_window != RST_CFG16) begin
                  state_next = ST_WATCH;
                  lwin_cnt_next = RST_CFG16;
                  lhit_cnt_next = RST_CNT8;
               end else if (lwin >= cfg_reg.lower_window) begin
                  lwin_cnt_next = RST_CFG16;
                  lhit_cnt_next = RST_CNT8;
               end else begin
                  lwin_cnt_next = lwin;
                  lhit_cnt_next = lhits;
               end
               uwin_cnt_next = RST_CFG16;
               uhit_cnt_next = RST_CNT8;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_WATCH;
         uwin_cnt_reg <= RST_CFG16;
         lwin_cnt_reg <= RST_CFG16;
         uhit_cnt_reg <= RST_CNT8;
         lhit_cnt_reg <= RST_CNT8;
      end else begin
         state_reg <= state_next;
         uwin_cnt_reg <= uwin_cnt_next;
         lwin_cnt_reg <= lwin_cnt_next;
         uhit_cnt_reg <= uhit_cnt_next;
         lhit_cnt_reg <= lhit_cnt_next;
      end
   end

   // ---------------- loop accumulator ----------------
   // the sample that raises the event still adds the normal error; injection
   // starts with the next sample, as the state is registered
   always_comb begin
      logic [SMP_W-1:0] err;
      err = (state_reg == ST_CLIP) ? cfg_reg.error_inject : normal_err_i;
      acc_next = acc_reg;
      if (sample_valid_i) begin
         acc_next = acc_reg + {{(ACC_W-SMP_W){err[SMP_W-1]}}, err};
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_reg <= RST_ACC;
      end else begin
         acc_reg <= acc_next;
      end
   end

   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign overload_o = state_reg;
   assign loop_accum_o = acc_reg;

endmodule // acd_clip_detector

// ### verilog/acd_pkg.sv
// Purpose: shared constants and carrier types for the overload (clip) detector
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes: register index times four gives the byte address
package acd_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned SMP_W = 16;
   localparam int unsigned CNT_W = 8;
   localparam int unsigned ACC_W = 32;
   localparam int unsigned IDX_W = 10;
   localparam int unsigned IDX_LSB = 2;

   // register indices
   localparam logic [IDX_W-1:0] IDX_UPPER_THRESH = 10'h032;
   localparam logic [IDX_W-1:0] IDX_LOWER_THRESH = 10'h033;
   localparam logic [IDX_W-1:0] IDX_UPPER_WINDOW = 10'h034;
   localparam logic [IDX_W-1:0] IDX_LOWER_WINDOW = 10'h035;
   localparam logic [IDX_W-1:0] IDX_SAMPLE_COUNTS = 10'h036;
   localparam logic [IDX_W-1:0] IDX_ERROR_INJECT = 10'h037;
   localparam logic [IDX_W-1:0] IDX_STATUS = 10'h03e;
   localparam logic [IDX_W-1:0] IDX_ACCUM = 10'h03f;

   // field positions of the sample count register
   localparam int unsigned FLD_UPPER_TGT_LSB = 8;
   localparam int unsigned FLD_LOWER_TGT_LSB = 0;
   // field positions of the status register
   localparam int unsigned FLD_ST_ACTIVE = 0;
   localparam int unsigned FLD_ST_UHITS_LSB = 8;
   localparam int unsigned FLD_ST_LHITS_LSB = 16;

   localparam logic [SMP_W-1:0] RST_CFG16 = 16'h0000;
   localparam logic [CNT_W-1:0] RST_CNT8 = 8'h00;
   localparam logic [ACC_W-1:0] RST_ACC = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;

   typedef enum logic [0:0] {
      ST_WATCH = 1'b0,
      ST_CLIP = 1'b1
   } acd_state_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } acd_apb_req_s;

   typedef struct packed {
      logic [SMP_W-1:0] upper_thresh;
      logic [SMP_W-1:0] lower_thresh;
      logic [SMP_W-1:0] upper_window;
      logic [SMP_W-1:0] lower_window;
      logic [CNT_W-1:0] upper_target;
      logic [CNT_W-1:0] lower_target;
      logic [SMP_W-1:0] error_inject;
   } acd_cfg_s;
endpackage
